//--- pss_core.sv
// Program sequencer core: program counter, return stack, vectors, table reads, ALU.
// Assumes same-clock program memory, decoder and interrupt controller, and an AHB-Lite master.
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"

module pss_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Program memory
   output logic [13:0] pm_addr,
   output logic pm_rd,
   input wire logic [15:0] pm_data,
   // Decoder
   output logic [15:0] instr_word,
   output logic instr_valid,
   input wire logic cmd_valid,
   input wire pss_pkg::pss_cmd_t cmd,
   output logic cmd_ready,
   input wire logic bank_select_b5,
   output logic [1:0] phase,
   // Interrupt controller: requests already enabled and flagged
   input wire logic [5:0] irq_req,
   output logic [5:0] irq_ack,
   // Results
   output logic [7:0] tbl_low_data,
   output logic tbl_low_valid,
   output logic [7:0] alu_result,
   output logic [3:0] alu_flags,
   output logic alu_valid
);
   pss_pkg::pss_state_t s;
   pss_pkg::pss_state_t n;
   pss_pkg::pss_alu_out_t alu;
   logic stack_full;
   logic irq_go;
   logic take;
   logic [2:0] irq_sel;
   logic [3:0] push_idx;
   logic [3:0] pop_idx;
   logic [5:0][13:0] vec;

   assign vec = {`PSS_VEC_MULTI, `PSS_VEC_SER, `PSS_VEC_TMR1,
                 `PSS_VEC_TMR0, `PSS_VEC_EXT1, `PSS_VEC_EXT0};

   // Depth is a define so the packed stack can live in the state struct
   assign stack_full = (s.stack_index == `PSS_STACK_FULL);
   // Overflowing push wraps onto the oldest entry; pop of an empty stack wraps too
   assign push_idx = stack_full ? 4'h0 : s.stack_index;
   assign pop_idx = (s.stack_index == 4'h0) ? `PSS_STACK_LAST : 4'(s.stack_index - 4'h1);
   // Controller owns enables and flags; only a free level is checked here
   assign irq_go = (s.phase == `PSS_PHASE_T1) && (s.cyc == pss_pkg::CYC_NORMAL)
                   && (|irq_req) && !stack_full;
   assign cmd_ready = (s.phase == `PSS_PHASE_T4) && (s.cyc == pss_pkg::CYC_NORMAL)
                      && s.fetched && !s.low_pend;
   assign take = cmd_ready && cmd_valid;

   always_comb begin
      irq_sel = 3'h5;
      for (int i = `PSS_IRQ_N - 1; i >= 0; i--) begin
         if (irq_req[i]) begin
            irq_sel = 3'(i);
         end
      end
   end

   function automatic pss_pkg::pss_alu_out_t alu_calc(input pss_pkg::pss_alu_op_t op,
         input logic [7:0] a, input logic [7:0] b, input logic [3:0] fl);
      pss_pkg::pss_alu_out_t o;
      logic [8:0] sum;
      logic [4:0] hs;
      logic cin;
      o.res = a;
      o.flags = fl;
      sum = 9'h000;
      hs = 5'h00;
      cin = 1'b0;
      unique case (op)
         pss_pkg::ALU_ADD, pss_pkg::ALU_ADC, pss_pkg::ALU_SUB, pss_pkg::ALU_SBC: begin
            if (op == pss_pkg::ALU_SUB) cin = 1'b1;
            else if (op != pss_pkg::ALU_ADD) cin = fl[`PSS_FLAG_C];
            // Subtract is add of the complement; carry set means no borrow
            if (op == pss_pkg::ALU_SUB || op == pss_pkg::ALU_SBC) b = ~b;
            sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            o.res = sum[7:0];
            o.flags[`PSS_FLAG_C] = sum[8];
            o.flags[`PSS_FLAG_AC] = hs[4];
            o.flags[`PSS_FLAG_OV] = (a[7] == b[7]) && (sum[7] != a[7]);
         end
         pss_pkg::ALU_DAA: begin
            sum = {1'b0, a};
            if (a[3:0] > 4'h9 || fl[`PSS_FLAG_AC]) sum = sum + 9'h006;
            if (sum[7:4] > 4'h9 || fl[`PSS_FLAG_C] || sum[8]) sum = sum + 9'h060;
            o.res = sum[7:0];
            o.flags[`PSS_FLAG_C] = sum[8] | fl[`PSS_FLAG_C];
         end
         pss_pkg::ALU_AND: o.res = a & b;
         pss_pkg::ALU_OR: o.res = a | b;
         pss_pkg::ALU_XOR: o.res = a ^ b;
         pss_pkg::ALU_CPL: o.res = ~a;
         pss_pkg::ALU_RR: o.res = {a[0], a[7:1]};
         pss_pkg::ALU_RL: o.res = {a[6:0], a[7]};
         pss_pkg::ALU_RRC: begin
            o.res = {fl[`PSS_FLAG_C], a[7:1]};
            o.flags[`PSS_FLAG_C] = a[0];
         end
         pss_pkg::ALU_RLC: begin
            o.res = {a[6:0], fl[`PSS_FLAG_C]};
            o.flags[`PSS_FLAG_C] = a[7];
         end
         pss_pkg::ALU_INC: o.res = 8'(a + 8'h01);
         pss_pkg::ALU_DEC: o.res = 8'(a - 8'h01);
         pss_pkg::ALU_PASS: o.res = a;
      endcase
      o.flags[`PSS_FLAG_Z] = (o.res == 8'h00);
      return o;
   endfunction : alu_calc

   assign alu = alu_calc(cmd.op, cmd.a, cmd.b, s.flags);

   always_comb begin
      n = s;
      n.phase = 2'(s.phase + 2'h1);
      n.pm_rd = 1'b0;
      n.tbl_valid = 1'b0;
      n.alu_valid = 1'b0;
      n.irq_ack = '0;
      n.hrdata = 32'h0000_0000;
      unique case (s.phase)
         `PSS_PHASE_T1: begin
            if (irq_go) begin
               // The acknowledge takes this cycle's fetch slot, so it costs a dummy
               n.stk[push_idx] = s.pc;
               n.stack_index = 4'(s.stack_index + 4'h1);
               n.pc = vec[irq_sel];
               n.irq_ack[irq_sel] = 1'b1;
               n.fetched = 1'b0;
            end else if (s.cyc == pss_pkg::CYC_NORMAL) begin
               n.pm_addr = s.pc;
               n.pm_rd = 1'b1;
               n.pc = 14'(s.pc + 14'h0001);
               n.fetched = 1'b1;
            end else if (s.cyc == pss_pkg::CYC_TABLE) begin
               n.pm_addr = s.taddr;
               n.pm_rd = 1'b1;
            end
         end
         `PSS_PHASE_T2: begin
            if (s.cyc == pss_pkg::CYC_NORMAL && s.fetched) begin
               n.instr = pm_data;
               n.instr_valid = 1'b1;
            end else if (s.cyc == pss_pkg::CYC_TABLE) begin
               n.tbl_low = pm_data[7:0];
               n.table_high_latch = pm_data[15:8];
               n.tbl_valid = 1'b1;
            end
         end
         2'h2: begin
         end
         `PSS_PHASE_T4: begin
            n.cyc = pss_pkg::CYC_NORMAL;
            n.fetched = 1'b0;
            n.instr_valid = 1'b0;
            if (s.cyc == pss_pkg::CYC_NORMAL && s.fetched && s.low_pend) begin
               // A bus write to the low byte displaces the fetched instruction
               n.pc = {s.pc[13:8], s.low_val};
               n.low_pend = 1'b0;
               n.cyc = pss_pkg::CYC_DUMMY;
            end else if (take) begin
               unique case (cmd.kind)
                  pss_pkg::K_ALU: begin
                     n.alu_res = alu.res;
                     n.flags = alu.flags;
                     n.alu_valid = 1'b1;
                     if (cmd.skip_zero && ((alu.res == 8'h00) ^ cmd.skip_inv)) begin
                        n.pc = 14'(s.pc + 14'h0001);
                        n.cyc = pss_pkg::CYC_DUMMY;
                     end
                  end
                  pss_pkg::K_SKIP: begin
                     if (cmd.skip_met) begin
                        n.pc = 14'(s.pc + 14'h0001);
                        n.cyc = pss_pkg::CYC_DUMMY;
                     end
                  end
                  pss_pkg::K_JUMP, pss_pkg::K_CALL: begin
                     if (cmd.kind == pss_pkg::K_CALL) begin
                        n.stk[push_idx] = s.pc;
                        n.stack_index = stack_full ? 4'h1 : 4'(s.stack_index + 4'h1);
                     end
                     n.pc = {bank_select_b5, cmd.target};
                     n.cyc = pss_pkg::CYC_DUMMY;
                  end
                  pss_pkg::K_SUB_RETURN, pss_pkg::K_INT_RETURN: begin
                     n.pc = s.stk[pop_idx];
                     n.stack_index = pop_idx;
                     n.cyc = pss_pkg::CYC_DUMMY;
                  end
                  pss_pkg::K_TRD_CUR, pss_pkg::K_TRD_LAST: begin
                     n.taddr = {(cmd.kind == pss_pkg::K_TRD_LAST) ? `PSS_LAST_PAGE
                               : s.pc[13:8], s.table_pointer};
                     n.cyc = pss_pkg::CYC_TABLE;
                  end
                  pss_pkg::K_PC_LOW_WR: begin
                     n.pc = {s.pc[13:8], cmd.a};
                     n.cyc = pss_pkg::CYC_DUMMY;
                  end
                  pss_pkg::K_NOP: begin
                  end
                  default: begin
                  end
               endcase
            end
         end
      endcase
      // Bus address phase; zero wait states, read data sampled here
      n.bus_act = hsel && htrans[1] && hready;
      n.bus_wr = hwrite;
      n.bus_addr = haddr;
      if (hsel && htrans[1] && hready && !hwrite) begin
         // The stack and its index have no address at all
         unique case (haddr)
            `PSS_REG_PC_LOW_BYTE: n.hrdata = {24'h000000, s.pc[7:0]};
            `PSS_REG_TABLE_POINTER: n.hrdata = {24'h000000, s.table_pointer};
            `PSS_REG_TABLE_HIGH: n.hrdata = {24'h000000, s.table_high_latch};
            `PSS_REG_STAT: n.hrdata = {27'h0000000, stack_full, s.flags};
            default: n.hrdata = 32'h0000_0000;
         endcase
      end
      if (s.bus_act && s.bus_wr) begin
         if (s.bus_addr == `PSS_REG_PC_LOW_BYTE) begin
            n.low_pend = 1'b1;
            n.low_val = hwdata[7:0];
         end else if (s.bus_addr == `PSS_REG_TABLE_POINTER) begin
            n.table_pointer = hwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.cyc <= pss_pkg::CYC_NORMAL;
         s.pc <= `PSS_PC_RST;
         s.stack_index <= 4'h0;
         s.table_pointer <= `PSS_TABLE_POINTER_RST;
         s.table_high_latch <= `PSS_TABLE_HIGH_RST;
         s.low_val <= `PSS_PC_LOW_RST;
      end else begin
         s <= n;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign pm_addr = s.pm_addr;
   assign pm_rd = s.pm_rd;
   assign instr_word = s.instr;
   assign instr_valid = s.instr_valid;
   assign phase = s.phase;
   assign irq_ack = s.irq_ack;
   assign tbl_low_data = s.tbl_low;
   assign tbl_low_valid = s.tbl_valid;
   assign alu_result = s.alu_res;
   assign alu_flags = s.flags;
   assign alu_valid = s.alu_valid;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_PC_SEQ: assert property ((s.phase == 2'h0) && !irq_go && s.cyc == pss_pkg::CYC_NORMAL
      |=> s.pc == 14'($past(s.pc) + 14'h0001) && pm_addr == $past(s.pc))
      else $error("pc did not advance by one on fetch");
   AST_LOW_WR: assert property (take && cmd.kind == pss_pkg::K_PC_LOW_WR
      |=> s.pc == {$past(s.pc[13:8]), $past(cmd.a)} && s.cyc == pss_pkg::CYC_DUMMY)
      else $error("low byte write left page or skipped dummy");
   AST_SKIP: assert property (take && cmd.kind == pss_pkg::K_SKIP && cmd.skip_met
      |=> s.pc == 14'($past(s.pc) + 14'h0001) ##1 !pm_rd [*4])
      else $error("skip did not discard and step by two");
   AST_RESET: assert property ($past(rst) |-> s.pc == 14'h0000 && s.stack_index == 4'h0)
      else $error("reset did not clear pc and stack index");
   AST_VEC_EXT0: assert property (irq_go && irq_req[0]
      |=> s.pc == 14'h0004 && irq_ack == 6'h01)
      else $error("external input 0 vector wrong");
   AST_VEC_MULTI: assert property (irq_go && irq_req == 6'h20
      |=> s.pc == 14'h0018 && irq_ack == 6'h20)
      else $error("multi-function vector wrong");
   AST_FULL_HOLD: assert property (stack_full |=> irq_ack == 6'h00)
      else $error("interrupt acknowledged on full stack");
   AST_JUMP: assert property (take && cmd.kind == pss_pkg::K_JUMP
      |=> s.pc == {$past(bank_select_b5), $past(cmd.target)} ##4 s.cyc == pss_pkg::CYC_NORMAL
      && !$past(pm_rd, 3))
      else $error("jump target or dummy cycle wrong");
   AST_CALL_RET: assert property (take && cmd.kind == pss_pkg::K_SUB_RETURN
      |=> s.pc == $past(s.stk[pop_idx]) && s.stack_index == $past(pop_idx))
      else $error("return did not restore pc");
   AST_TABLE: assert property (take && cmd.kind == pss_pkg::K_TRD_LAST
      |=> s.taddr == {6'h3F, $past(s.table_pointer)} ##1 pm_addr == s.taddr ##1 tbl_low_valid)
      else $error("last page table read wrong");
   AST_ZERO: assert property (alu_valid |-> alu_flags[2] == (alu_result == 8'h00))
      else $error("zero flag disagrees with result");
endmodule : pss_core
`default_nettype wire

//--- pss_consts.svh
// Constants of the program sequencer: vectors, register offsets, field positions, reset values.
// Assumes inclusion by the package, the core and the testbench.
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
`define PSS_PC_W 14
`define PSS_STACK_DEPTH 8
`define PSS_STACK_FULL 4'h8
`define PSS_STACK_LAST 4'h7
`define PSS_IRQ_N 6
`define PSS_PC_RST 14'h0000
`define PSS_VEC_EXT0 14'h0004
`define PSS_VEC_EXT1 14'h0008
`define PSS_VEC_TMR0 14'h000C
`define PSS_VEC_TMR1 14'h0010
`define PSS_VEC_SER 14'h0014
`define PSS_VEC_MULTI 14'h0018
`define PSS_LAST_PAGE 6'h3F
`define PSS_PHASE_T1 2'h0
`define PSS_PHASE_T2 2'h1
`define PSS_PHASE_T4 2'h3
`define PSS_REG_PC_LOW_BYTE 32'h0000_0000
`define PSS_REG_TABLE_POINTER 32'h0000_0004
`define PSS_REG_TABLE_HIGH 32'h0000_0008
`define PSS_REG_STAT 32'h0000_000C
`define PSS_PC_LOW_RST 8'h00
`define PSS_TABLE_POINTER_RST 8'h00
`define PSS_TABLE_HIGH_RST 8'h00
`define PSS_FLAG_C 0
`define PSS_FLAG_AC 1
`define PSS_FLAG_Z 2
`define PSS_FLAG_OV 3
`define PSS_STAT_FULL 4
`endif

//--- pss_pkg.sv
// Types shared by the program sequencer core and its surroundings.
// Assumes pss_consts.svh is on the include path.
`include "pss_consts.svh"
package pss_pkg;
   typedef enum logic [2:0] {
      CYC_NORMAL = 3'b001,
      CYC_DUMMY = 3'b010,
      CYC_TABLE = 3'b100
   } pss_cyc_t;

   typedef enum logic [3:0] {
      K_NOP = 4'h0,
      K_ALU = 4'h1,
      K_SKIP = 4'h2,
      K_JUMP = 4'h3,
      K_CALL = 4'h4,
      K_SUB_RETURN = 4'h5,
      K_INT_RETURN = 4'h6,
      K_TRD_CUR = 4'h7,
      K_TRD_LAST = 4'h8,
      K_PC_LOW_WR = 4'h9
   } pss_kind_t;

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
      ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_XOR = 4'h7,
      ALU_CPL = 4'h8, ALU_RR = 4'h9, ALU_RRC = 4'hA, ALU_RL = 4'hB,
      ALU_RLC = 4'hC, ALU_INC = 4'hD, ALU_DEC = 4'hE, ALU_PASS = 4'hF
   } pss_alu_op_t;

   typedef struct packed {
      pss_kind_t kind;
      pss_alu_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic skip_zero;
      logic skip_inv;
      logic skip_met;
      logic [12:0] target;
   } pss_cmd_t;

   typedef struct packed {
      logic [7:0] res;
      logic [3:0] flags;
   } pss_alu_out_t;

   typedef struct packed {
      logic [1:0] phase;
      pss_cyc_t cyc;
      logic fetched;
      logic [`PSS_PC_W-1:0] pc;
      logic [`PSS_PC_W-1:0] taddr;
      logic [`PSS_STACK_DEPTH-1:0][`PSS_PC_W-1:0] stk;
      logic [3:0] stack_index;
      logic [7:0] table_pointer;
      logic [7:0] table_high_latch;
      logic low_pend;
      logic [7:0] low_val;
      logic [`PSS_PC_W-1:0] pm_addr;
      logic pm_rd;
      logic [15:0] instr;
      logic instr_valid;
      logic [7:0] tbl_low;
      logic tbl_valid;
      logic [7:0] alu_res;
      logic alu_valid;
      logic [3:0] flags;
      logic [`PSS_IRQ_N-1:0] irq_ack;
      logic bus_act;
      logic bus_wr;
      logic [31:0] bus_addr;
      logic [31:0] hrdata;
   } pss_state_t;
endpackage : pss_pkg

//--- pss_pmem_model.sv
// Program memory model: one 16-bit word for each 14-bit address.
// Assumes the core samples pm_data at the edge that ends its pm_rd pulse.
`timescale 1ns/1ns
`default_nettype none
module pss_pmem_model (
   // Clock
   input wire logic clk,
   // Read port
   input wire logic [13:0] pm_addr,
   input wire logic pm_rd,
   output logic [15:0] pm_data
);
   logic [15:0] last = 16'h0000;
   // Outside a read the lines toggle, so a sample one cycle late sees the complement
   always_comb begin
      if (pm_rd) begin
         pm_data = {pm_addr[7:0] ^ 8'h3C, 2'h0, pm_addr[13:8]};
      end else begin
         pm_data = ~last;
      end
   end
   always @(posedge clk) begin
      last <= pm_data;
   end
endmodule : pss_pmem_model
`default_nettype wire

//--- testbench.sv
// Bench of the program sequencer core, with a model of its counter and stack.
// Assumes pss_pkg, pss_consts.svh and the program memory model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"
module testbench;
   // Bus
   logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   // Core side
   logic [13:0] pm_addr;
   logic [15:0] pm_data, instr_word, w;
   logic pm_rd, instr_valid, cmd_valid, cmd_ready, bank_select_b5, tbl_low_valid, alu_valid;
   pss_pkg::pss_cmd_t cmd;
   logic [1:0] phase;
   logic [5:0] irq_req, irq_ack, flagv;
   logic [7:0] tbl_low_data, alu_result, tptr_m, sync_val;
   logic [3:0] alu_flags;
   // Model
   int num_errors = 0;
   int num_checks = 0;
   int gap = 4;
   int cnt = 0;
   logic first = 1'h1;
   logic resync = 1'h0;
   logic tbl_wait = 1'h0;
   logic instr_chk = 1'h0;
   logic [16:0] instr_exp;
   logic [13:0] pc_exp = 14'h0000;
   logic [13:0] tbl_exp;
   logic [13:0] stk_q [$];
   logic [31:0] lfsr = 32'h3834;
   logic [13:0] vec [6] = '{`PSS_VEC_EXT0, `PSS_VEC_EXT1, `PSS_VEC_TMR0,
      `PSS_VEC_TMR1, `PSS_VEC_SER, `PSS_VEC_MULTI};
   pss_pkg::pss_alu_op_t ops [5] = '{pss_pkg::ALU_ADD, pss_pkg::ALU_SUB,
      pss_pkg::ALU_AND, pss_pkg::ALU_OR, pss_pkg::ALU_XOR};

   assign hready = hreadyout;
   assign flagv = {~resync, |irq_ack, tbl_low_valid, alu_valid, cmd_ready, hready};

   pss_core i_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout, .hresp, .hrdata, .pm_addr, .pm_rd, .pm_data, .instr_word, .instr_valid,
      .cmd_valid, .cmd, .cmd_ready, .bank_select_b5, .phase, .irq_req, .irq_ack,
      .tbl_low_data, .tbl_low_valid, .alu_result, .alu_flags, .alu_valid);
   pss_pmem_model i_mem (.clk, .pm_addr, .pm_rd, .pm_data);

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   function automatic int low1(logic [5:0] v);
      for (int i = 5; i >= 0; i--) begin
         if (v[i]) low1 = i;
      end
   endfunction : low1

   function automatic logic [8:0] alu_ref(pss_pkg::pss_alu_op_t op, logic [7:0] a, logic [7:0] b);
      case (op)
         pss_pkg::ALU_ADD: return {1'h0, a} + {1'h0, b};
         pss_pkg::ALU_SUB: return {a >= b, a - b};
         pss_pkg::ALU_AND: return {1'h0, a & b};
         pss_pkg::ALU_OR: return {1'h0, a | b};
         default: return {1'h0, a ^ b};
      endcase
   endfunction : alu_ref

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Every wait is bounded; running out ends the run as a mismatch
   task automatic wait_hi(input int k, input string what);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (flagv[k] !== 1'h1 && n < 80);
      if (n >= 80) begin
         num_errors++;
         $display("Error %s expected 1 seen timeout", what);
         end_sim();
      end
   endtask : wait_hi

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_hi(0, "hready");
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_hi(0, "hready");
      rd = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask : ahb

   task automatic issue(input pss_pkg::pss_kind_t k, input logic [7:0] a, input logic [7:0] b,
         input pss_pkg::pss_alu_op_t op);
      logic [8:0] r;
      @(posedge clk);
      cmd <= '{kind: k, op: op, a: a, b: b, skip_zero: 1'h0, skip_inv: 1'h0,
         skip_met: a[0], target: {a[4:0], b}};
      cmd_valid <= 1'h1;
      bank_select_b5 <= b[7];
      wait_hi(1, "cmd_ready");
      chk("take_phase", 32'(`PSS_PHASE_T4), 32'(phase));
      cmd_valid <= 1'h0;
      r = alu_ref(op, a, b);
      if (k inside {pss_pkg::K_JUMP, pss_pkg::K_CALL, pss_pkg::K_SUB_RETURN,
            pss_pkg::K_INT_RETURN, pss_pkg::K_PC_LOW_WR} || (k == pss_pkg::K_SKIP && a[0])) gap += 4;
      tbl_exp = {(k == pss_pkg::K_TRD_LAST) ? `PSS_LAST_PAGE : pc_exp[13:8], tptr_m};
      case (k)
         pss_pkg::K_JUMP: pc_exp = {b[7], a[4:0], b};
         pss_pkg::K_CALL: begin
            stk_q.push_back(pc_exp);
            pc_exp = {b[7], a[4:0], b};
         end
         pss_pkg::K_SUB_RETURN, pss_pkg::K_INT_RETURN: pc_exp = stk_q.pop_back();
         pss_pkg::K_SKIP: pc_exp = pc_exp + 14'(a[0]);
         pss_pkg::K_PC_LOW_WR: pc_exp[7:0] = a;
         pss_pkg::K_ALU: begin
            wait_hi(2, "alu_valid");
            chk("alu_result", 32'(r[7:0]), 32'(alu_result));
            chk("zero_flag", 32'(r[7:0] == 8'h00), 32'(alu_flags[`PSS_FLAG_Z]));
            chk("carry_flag", 32'(r[8] & op < 4'h4), 32'(alu_flags[`PSS_FLAG_C] & op < 4'h4));
         end
         pss_pkg::K_TRD_CUR, pss_pkg::K_TRD_LAST: begin
            tbl_wait = 1'h1;
            w = pm_word(tbl_exp);
            wait_hi(3, "tbl_low_valid");
            chk("table_low", 32'(w[7:0]), 32'(tbl_low_data));
            ahb(1'h0, `PSS_REG_TABLE_HIGH, 32'h0);
            chk("table_high", 32'(w[15:8]), rd);
         end
         default: ;
      endcase
   endtask : issue

   function automatic logic [15:0] pm_word(logic [13:0] a);
      return {a[7:0] ^ 8'h3C, 2'h0, a[13:8]};
   endfunction : pm_word

   task automatic raise(input logic [5:0] req);
      issue(pss_pkg::K_NOP, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      irq_req <= req;
   endtask : raise

   // Follows every fetch outside a resync, every table read and acknowledge against the model
   always @(posedge clk) begin
      if (!rst) begin
         cnt++;
         if (instr_chk) begin
            chk("instr_word", 32'(instr_exp), 32'({instr_valid, instr_word}));
            instr_chk = 1'h0;
         end
         if (irq_ack !== 6'h00) begin
            chk("irq_ack", 32'(irq_req & (~irq_req + 6'h01)), 32'(irq_ack));
            chk("stack_room", 32'h1, 32'(stk_q.size() < 8));
            stk_q.push_back(pc_exp);
            pc_exp = vec[low1(irq_req)];
            gap += 4;
         end
         if (pm_rd === 1'h1) begin
            if (tbl_wait) begin
               chk("table_addr", 32'(tbl_exp), 32'(pm_addr));
               tbl_wait = 1'h0;
            end else if (!resync) begin
               chk("fetch", 32'(pc_exp), 32'(pm_addr));
               if (!first) chk("gap", 32'(gap), 32'(cnt));
               pc_exp++;
               instr_exp = {1'h1, pm_word(pm_addr)};
               instr_chk = 1'h1;
            end else if (pm_addr[7:0] == sync_val) begin
               chk("page", 32'(pc_exp[13:8]), 32'(pm_addr[13:8]));
               pc_exp = pm_addr + 14'h0001;
               resync = 1'h0;
            end
            first = 1'h0;
            cnt = 0;
            gap = 4;
         end
      end
   end

   initial begin
      rst = 1'h1;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      cmd_valid = 1'h0;
      cmd = '0;
      bank_select_b5 = 1'h0;
      irq_req = 6'h00;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      ahb(1'h0, `PSS_REG_TABLE_POINTER, 32'h0);
      chk("table_pointer_reset", 32'(`PSS_TABLE_POINTER_RST), rd);
      ahb(1'h0, `PSS_REG_STAT, 32'h0);
      chk("status_reset", 32'h0, rd);
      tptr_m = 8'(rnd());
      ahb(1'h1, `PSS_REG_TABLE_POINTER, 32'(tptr_m));
      ahb(1'h1, `PSS_REG_TABLE_HIGH, 32'hFF);
      ahb(1'h1, 32'h10, 32'hFF);
      ahb(1'h0, `PSS_REG_TABLE_POINTER, 32'h0);
      chk("table_pointer_rw", 32'(tptr_m), rd);
      ahb(1'h0, `PSS_REG_TABLE_HIGH, 32'h0);
      chk("table_high_ro", 32'(`PSS_TABLE_HIGH_RST), rd);
      ahb(1'h0, 32'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test registers done");
      foreach (ops[i]) issue(pss_pkg::K_ALU, 8'(rnd()), 8'(rnd()), ops[i]);
      $display("test alu done");
      issue(pss_pkg::K_JUMP, 8'(rnd()), 8'(rnd()), pss_pkg::ALU_PASS);
      issue(pss_pkg::K_SKIP, 8'h01, 8'h00, pss_pkg::ALU_PASS);
      issue(pss_pkg::K_SKIP, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      issue(pss_pkg::K_PC_LOW_WR, 8'(rnd()), 8'h00, pss_pkg::ALU_PASS);
      issue(pss_pkg::K_CALL, 8'(rnd()), 8'(rnd()), pss_pkg::ALU_PASS);
      issue(pss_pkg::K_TRD_CUR, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      issue(pss_pkg::K_SUB_RETURN, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      issue(pss_pkg::K_TRD_LAST, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      $display("test flow done");
      for (int i = 0; i < 6; i++) begin
         raise(6'(6'h3F << i));
         wait_hi(4, "irq_ack");
         irq_req <= 6'h00;
         issue(pss_pkg::K_INT_RETURN, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      end
      $display("test vectors done");
      repeat (8) issue(pss_pkg::K_CALL, 8'(rnd()), 8'(rnd()), pss_pkg::ALU_PASS);
      ahb(1'h0, `PSS_REG_STAT, 32'h0);
      chk("stack_full", 32'h1, 32'(rd[`PSS_STAT_FULL]));
      // A full stack must hold the request back across these cycles
      raise(6'h04);
      repeat (2) issue(pss_pkg::K_NOP, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      issue(pss_pkg::K_SUB_RETURN, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      wait_hi(4, "irq_ack");
      irq_req <= 6'h00;
      repeat (8) issue(pss_pkg::K_INT_RETURN, 8'h00, 8'h00, pss_pkg::ALU_PASS);
      $display("test full stack done");
      issue(pss_pkg::K_JUMP, 8'h01, 8'h00, pss_pkg::ALU_PASS);
      sync_val = 8'hC0 | 8'(rnd() & 32'hF);
      resync = 1'h1;
      ahb(1'h1, `PSS_REG_PC_LOW_BYTE, 32'(sync_val));
      wait_hi(5, "low_byte_branch");
      ahb(1'h0, `PSS_REG_PC_LOW_BYTE, 32'h0);
      chk("low_byte_upper", 32'h0, {8'h00, rd[31:8]});
      $display("test low byte done");
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      $display("Error watchdog expected finish seen timeout");
      end_sim();
   end
endmodule : testbench
`default_nettype wire
